/* File: hw/sfs_pkg.sv */
package sfs_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned NUM_CH          = 5;
  // Deglitch times in ns; only the typical time sets the cycle count, rounded down
  localparam int unsigned UVOV_DGL_MIN_NS = 2000;
  localparam int unsigned UVOV_DGL_TYP_NS = 3500;
  localparam int unsigned UVOV_DGL_MAX_NS = 5500;
  localparam int unsigned CP_DGL_TYP_NS   = 4000;
  localparam int unsigned CP_DGL_MAX_NS   = 6000;
  localparam int unsigned OTS_DGL_MIN_NS  = 2000;
  localparam int unsigned OTS_DGL_TYP_NS  = 5000;
  localparam int unsigned OTS_DGL_MAX_NS  = 10000;
  localparam int unsigned UVOV_DGL_CYC    = UVOV_DGL_TYP_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned CP_DGL_CYC      = CP_DGL_TYP_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned OTS_DGL_CYC     = OTS_DGL_TYP_NS / (1_000_000_000 / CLK_HZ);
  // Autorestart in ms
  localparam int unsigned AUTO_RESTART_MS  = 64;
  localparam int unsigned AUTO_RESTART_CYC = AUTO_RESTART_MS * (CLK_HZ / 1000);
  localparam int unsigned DGL_CW          = 10;
  // Register byte offsets
  localparam logic [7:0] ADDR_QUICK_STAT  = 8'h04;
  localparam logic [7:0] ADDR_CH_STAT     = 8'h08;
  localparam logic [7:0] ADDR_SUPV_STAT   = 8'h1C;
  localparam logic [7:0] ADDR_OUT_CTRL    = 8'h20;
  localparam logic [7:0] ADDR_CONFIG      = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h2C;
  // Field positions
  localparam int unsigned BIT_DFS         = 31;
  localparam int unsigned BIT_UVF         = 0;
  localparam int unsigned BIT_OVF         = 1;
  localparam int unsigned BIT_CPF         = 0;
  localparam int unsigned BIT_FAIL_MODE   = 0;
  localparam int unsigned BIT_WARN_SEL    = 1;
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;
  localparam logic [4:0] OUT_CTRL_RST     = 5'h00;
  localparam logic [1:0] CONFIG_RST       = 2'h0;
  localparam logic [3:0] IRQ_MASK_RST     = 4'h0;
endpackage

/* File: hw/sfs_deglitch.sv */
module sfs_deglitch import sfs_pkg::*; #(
  parameter int unsigned CYCLES = 140
) (
  input  wire logic ref_clk,   // System clock
  input  wire logic srst,      // Sync reset
  input  wire logic raw_in,    // Synchronised detector level
  output logic      filt_out   // Deglitched level
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic          out_q, out_d;

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!raw_in) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (cnt_q == CW'(CYCLES - 1)) begin
      out_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign filt_out = out_q;
endmodule

/* File: hw/sfs_supervisor.sv */
// Overview of operation
// R1: Undervoltage held through its deglitch time switches all five outputs off.
// R2: Deglitched undervoltage sets undervoltage flag and summary fault flag.
// R3: Normal mode: outputs stay off after undervoltage until host rewrites on bits.
// R4: Undervoltage flag clears only when condition gone and supervision status read.
// R5: Fail mode restarts outputs automatically after undervoltage shutdown.
// R6: Automatic restart retries a faulted output after about 64 ms.
// R7: Deglitched overvoltage sets its flag and summary; clears after gone and read.
// R8: Outputs held off until pump settles; pending turn-on executes at settle.
// R9: Pump out of range through its deglitch time disables all outputs.
// R10: Deglitched pump failure sets pump fault flag and summary fault flag.
// R11: Turn-on during pump failure executes at pump valid, starting overcurrent windows.
// R12: Pump fault flag clears only when failure gone and quick status read.
// R13: Overtemperature shutdown deglitched about 5 us before channel off and report.
// R14: Warning select bit: 0 chooses high threshold (reset), 1 the low one.
// R15: Each deglitch counts only while input stays high, restarting on any drop.
// R16: Summary fault flag is OR of latched UV, OV, pump flags, in quick, channel and supervision status.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
module sfs_supervisor import sfs_pkg::*; #(
  parameter int unsigned RESTART_CYC = AUTO_RESTART_CYC
) (
  input  wire logic              ref_clk,                  // 40 MHz clock
  input  wire logic              srst,                     // Sync reset, active high
  input  wire logic              uv_det,                   // Undervoltage detector pin
  input  wire logic              ov_det,                   // Overvoltage detector pin
  input  wire logic              pump_bad_det,             // Pump out of range pin
  input  wire logic [NUM_CH-1:0] ots_det,                  // Overtemp shutdown pins
  output logic [NUM_CH-1:0]      power_outputs,            // Channel gate enables
  output logic [NUM_CH-1:0]      high_overcurrent_window,  // Window start pulses
  output logic                   warn_threshold_select,    // 1 selects low threshold
  output logic                   irq,                      // Level interrupt
  input  wire logic [7:0]        s_axi_awaddr,             // AXI write address
  input  wire logic              s_axi_awvalid,            // AXI
  output logic                   s_axi_awready,            // AXI
  input  wire logic [31:0]       s_axi_wdata,              // AXI write data
  input  wire logic [3:0]        s_axi_wstrb,              // AXI byte strobes
  input  wire logic              s_axi_wvalid,             // AXI
  output logic                   s_axi_wready,             // AXI
  output logic [1:0]             s_axi_bresp,              // AXI
  output logic                   s_axi_bvalid,             // AXI
  input  wire logic              s_axi_bready,             // AXI
  input  wire logic [7:0]        s_axi_araddr,             // AXI read address
  input  wire logic              s_axi_arvalid,            // AXI
  output logic                   s_axi_arready,            // AXI
  output logic [31:0]            s_axi_rdata,              // AXI read data
  output logic [1:0]             s_axi_rresp,              // AXI
  output logic                   s_axi_rvalid,             // AXI
  input  wire logic              s_axi_rready              // AXI
);
  localparam int unsigned NIN = NUM_CH + 3;
  localparam int unsigned RCW = $clog2(RESTART_CYC + 1);

  // Two-stage synchronisers for every detector pin
  // Pump bit resets high so power-up stays unsettled until the pin is seen low
  localparam logic [NIN-1:0] SYNC_RST = {{(NIN-3){1'b0}}, 3'h4};
  logic [NIN-1:0] s1_q, s2_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_q <= SYNC_RST; // [R8]
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= {ots_det, pump_bad_det, ov_det, uv_det};
      s2_q <= s1_q;
    end
  end

  logic              uv_f, ov_f, cp_f;
  logic [NUM_CH-1:0] ots_f;
  sfs_deglitch #(.CYCLES(UVOV_DGL_CYC)) u_dg_uv ( // [R15]
    .ref_clk  (ref_clk),
    .srst     (srst),
    .raw_in   (s2_q[0]),
    .filt_out (uv_f)
  );
  sfs_deglitch #(.CYCLES(UVOV_DGL_CYC)) u_dg_ov (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .raw_in   (s2_q[1]),
    .filt_out (ov_f)
  );
  sfs_deglitch #(.CYCLES(CP_DGL_CYC)) u_dg_cp (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .raw_in   (s2_q[2]),
    .filt_out (cp_f)
  );
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ots
    sfs_deglitch #(.CYCLES(OTS_DGL_CYC)) u_dg_ots ( // [R13]
      .ref_clk  (ref_clk),
      .srst     (srst),
      .raw_in   (s2_q[3+i]),
      .filt_out (ots_f[i])
    );
  end

  // Register state
  logic [NUM_CH-1:0] on_cmd_q, on_cmd_d;      // Host on bits
  logic [NUM_CH-1:0] out_q, out_d;            // Gate state
  logic [NUM_CH-1:0] ots_flag_q, ots_flag_d;
  logic [NUM_CH-1:0] win_q, win_d;
  logic              settled_q, settled_d;    // Pump has settled once
  logic              uvf_q, uvf_d;
  logic              ovf_q, ovf_d;
  logic              cpf_q, cpf_d;
  logic [1:0]        cfg_q, cfg_d;
  logic [3:0]        ist_q, ist_d, imask_q, imask_d;
  logic [RCW-1:0]    rst_cnt_q, rst_cnt_d;
  logic              uv_prev_q, ov_prev_q, cp_prev_q;
  logic [NUM_CH-1:0] ots_prev_q;
  // Bus state
  logic              aw_q, aw_d;
  logic              w_q, w_d;
  logic              b_q, b_d;
  logic              r_q, r_d;
  logic [7:0]        awa_q, awa_d;
  logic [31:0]       wd_q, wd_d, rd_q, rd_d;
  logic [3:0]        ws_q, ws_d;
  logic [1:0]        br_q, br_d, rr_q, rr_d;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == ADDR_QUICK_STAT) || (a == ADDR_CH_STAT) || (a == ADDR_SUPV_STAT) ||
                 (a == ADDR_OUT_CTRL) || (a == ADDR_CONFIG) || (a == ADDR_IRQ_STAT) ||
                 (a == ADDR_IRQ_MASK);
  endfunction

  logic dfs;
  assign dfs = uvf_q | ovf_q | cpf_q; // [R16]

  logic supply_bad, fail_mode, do_wr, do_rd, rd_supv, rd_quick, rd_ist;
  logic [3:0] ev;
  assign supply_bad = uv_f | cp_f | !settled_q;
  assign fail_mode  = cfg_q[BIT_FAIL_MODE];
  assign do_wr      = aw_q && w_q && !b_q;
  assign do_rd      = s_axi_arvalid && s_axi_arready;
  assign rd_supv    = do_rd && (s_axi_araddr == ADDR_SUPV_STAT);
  assign rd_quick   = do_rd && (s_axi_araddr == ADDR_QUICK_STAT);
  assign rd_ist     = do_rd && (s_axi_araddr == ADDR_IRQ_STAT);
  assign ev = {|(ots_f & ~ots_prev_q), cp_f & !cp_prev_q, ov_f & !ov_prev_q, uv_f & !uv_prev_q};

  always_comb begin
    on_cmd_d   = on_cmd_q;
    cfg_d      = cfg_q;
    imask_d    = imask_q;
    ist_d      = ist_q;
    uvf_d      = uvf_q;
    ovf_d      = ovf_q;
    cpf_d      = cpf_q;
    ots_flag_d = ots_flag_q;
    settled_d  = settled_q | !s2_q[2];
    rst_cnt_d  = rst_cnt_q;
    // Read clear first so a fresh event below wins
    if (rd_supv && !uv_f) uvf_d = 1'b0;                         // [R4]
    if (rd_supv && !ov_f) ovf_d = 1'b0;                         // [R7]
    if (rd_quick && !cp_f) cpf_d = 1'b0;                        // [R12]
    if (do_rd && (s_axi_araddr == ADDR_CH_STAT)) ots_flag_d = ots_flag_q & ots_f;
    if (rd_ist) ist_d = '0;
    if (uv_f) uvf_d = 1'b1;                                     // [R2]
    if (ov_f) ovf_d = 1'b1;                                     // [R7]
    if (cp_f) cpf_d = 1'b1;                                     // [R10]
    ots_flag_d = ots_flag_d | ots_f;                            // [R13]
    ist_d = ist_d | ev;
    if (do_wr) begin
      unique case (awa_q)
        ADDR_OUT_CTRL: if (ws_q[0]) on_cmd_d = wd_q[NUM_CH-1:0]; // [R3]
        ADDR_CONFIG:   if (ws_q[0]) cfg_d = wd_q[1:0];         // [R14]
        ADDR_IRQ_MASK: if (ws_q[0]) imask_d = wd_q[3:0];
        default: ;
      endcase
    end
    // Normal mode: an undervoltage or overtemperature shutdown drops the on bit so the host must rewrite it
    if (!fail_mode) begin
      if (uv_f) on_cmd_d = '0;                                  // [R3]
      on_cmd_d = on_cmd_d & ~ots_f;
    end
    // Fail mode: hold the restart timer while undervoltage persists, then count down
    if (fail_mode && uv_f) rst_cnt_d = RCW'(RESTART_CYC);       // [R5]
    else if (rst_cnt_q != '0) rst_cnt_d = rst_cnt_q - RCW'(1);  // [R6]
  end

  // Gate drive; pending on bits pass only once the pump is settled and valid
  always_comb begin
    out_d = on_cmd_q & ~ots_f;
    if (supply_bad || (rst_cnt_q != '0)) out_d = '0;            // [R1] [R8] [R9] [R6]
    win_d = out_d & ~out_q;                                     // [R11]
  end

  // AXI4-Lite slave
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    b_d   = b_q;
    r_d   = r_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    br_d  = br_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = known_addr(awa_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (r_q && s_axi_rready) r_d = 1'b0;
    if (do_rd) begin
      r_d  = 1'b1;
      rr_d = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rd_d = '0;
      unique case (s_axi_araddr)
        ADDR_QUICK_STAT: rd_d[BIT_CPF] = cpf_q;
        ADDR_CH_STAT:    rd_d[NUM_CH-1:0] = ots_flag_q;
        ADDR_SUPV_STAT:  rd_d[1:0] = {ovf_q, uvf_q};
        ADDR_OUT_CTRL:   rd_d[NUM_CH-1:0] = on_cmd_q;
        ADDR_CONFIG:     rd_d[1:0] = cfg_q;
        ADDR_IRQ_STAT:   rd_d[3:0] = ist_q;
        ADDR_IRQ_MASK:   rd_d[3:0] = imask_q;
        default: ;
      endcase
      if (s_axi_araddr inside {ADDR_QUICK_STAT, ADDR_CH_STAT, ADDR_SUPV_STAT}) rd_d[BIT_DFS] = dfs; // [R16]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      on_cmd_q   <= OUT_CTRL_RST;
      out_q      <= '0;
      ots_flag_q <= '0;
      win_q      <= '0;
      settled_q  <= 1'b0;
      uvf_q      <= 1'b0;
      ovf_q      <= 1'b0;
      cpf_q      <= 1'b0;
      cfg_q      <= CONFIG_RST;
      ist_q      <= '0;
      imask_q    <= IRQ_MASK_RST;
      rst_cnt_q  <= '0;
      uv_prev_q  <= 1'b0;
      ov_prev_q  <= 1'b0;
      cp_prev_q  <= 1'b0;
      ots_prev_q <= '0;
      aw_q       <= 1'b0;
      w_q        <= 1'b0;
      b_q        <= 1'b0;
      r_q        <= 1'b0;
      awa_q      <= '0;
      wd_q       <= '0;
      ws_q       <= '0;
      br_q       <= RESP_OKAY;
      rd_q       <= '0;
      rr_q       <= RESP_OKAY;
    end else begin
      on_cmd_q   <= on_cmd_d;
      out_q      <= out_d;
      ots_flag_q <= ots_flag_d;
      win_q      <= win_d;
      settled_q  <= settled_d;
      uvf_q      <= uvf_d;
      ovf_q      <= ovf_d;
      cpf_q      <= cpf_d;
      cfg_q      <= cfg_d;
      ist_q      <= ist_d;
      imask_q    <= imask_d;
      rst_cnt_q  <= rst_cnt_d;
      uv_prev_q  <= uv_f;
      ov_prev_q  <= ov_f;
      cp_prev_q  <= cp_f;
      ots_prev_q <= ots_f;
      aw_q       <= aw_d;
      w_q        <= w_d;
      b_q        <= b_d;
      r_q        <= r_d;
      awa_q      <= awa_d;
      wd_q       <= wd_d;
      ws_q       <= ws_d;
      br_q       <= br_d;
      rd_q       <= rd_d;
      rr_q       <= rr_d;
    end
  end

  // One write and one read in flight; channels stall until the answer drains
  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  assign power_outputs           = out_q;
  assign high_overcurrent_window = win_q;
  assign warn_threshold_select   = cfg_q[BIT_WARN_SEL]; // [R14]
  assign irq                     = |(ist_q & imask_q);
endmodule

/* File: bench/sfs_supervisor_chk.sv */
module sfs_supervisor_chk import sfs_pkg::*; (
  input wire logic              ref_clk,                  // Clock
  input wire logic              srst,                     // Reset
  input wire logic              uv_det,                   // Undervoltage in
  input wire logic              pump_bad_det,             // Pump fault in
  input wire logic [NUM_CH-1:0] power_outputs,            // Gate enables
  input wire logic [NUM_CH-1:0] high_overcurrent_window,  // Window pulses
  input wire logic              warn_threshold_select,    // Warn select
  input wire logic              s_axi_arvalid,            // AXI
  input wire logic              s_axi_arready,            // AXI
  input wire logic              s_axi_rvalid              // AXI
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] uv_q, uv_d, cp_q, cp_d;
  logic       seen_q, seen_d;
  // Saturating run lengths; margin covers the two sync stages
  always_comb begin
    uv_d   = uv_det ? uv_q + {8'h00, uv_q != 9'h1FF} : 9'h000;
    cp_d   = pump_bad_det ? cp_q + {8'h00, cp_q != 9'h1FF} : 9'h000;
    seen_d = seen_q || !pump_bad_det;
  end
  always_ff @(posedge ref_clk) begin
    uv_q   <= srst ? 9'h000 : uv_d;
    cp_q   <= srst ? 9'h000 : cp_d;
    seen_q <= srst ? 1'b0 : seen_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_uv_off: assert property (uv_q >= 9'h096 |-> power_outputs == '0)
    else $error("outputs on during long undervoltage");
  a_pump_off: assert property (cp_q >= 9'h0AA |-> power_outputs == '0)
    else $error("outputs on during long pump failure");
  a_unsettled_off: assert property (!seen_q |-> power_outputs == '0)
    else $error("outputs on before pump settled");
  a_reset_off: assert property ($fell(srst) |-> power_outputs == '0 [*2])
    else $error("outputs on right after reset");
  a_warn_default: assert property ($fell(srst) |-> !warn_threshold_select)
    else $error("warn select not low after reset");
  a_on_window: assert property ($rose(power_outputs[0]) |-> ##[0:1] high_overcurrent_window[0])
    else $error("turn-on without window start");
  a_window_pulse: assert property (high_overcurrent_window[0] |=> !high_overcurrent_window[0])
    else $error("window start longer than one cycle");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_uv_long: cover property (uv_q == 9'h096);
  c_turn_on: cover property ($rose(power_outputs[4]));
  c_warn_low: cover property ($rose(warn_threshold_select));
endmodule

bind sfs_supervisor sfs_supervisor_chk chk_u (
  .ref_clk(ref_clk), .srst(srst), .uv_det(uv_det), .pump_bad_det(pump_bad_det),
  .power_outputs(power_outputs), .high_overcurrent_window(high_overcurrent_window),
  .warn_threshold_select(warn_threshold_select), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

/* File: bench/sfs_host.sv */
module sfs_host (
  input wire logic ref_clk  // Bus clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  // Readies settle by the falling edge; taken at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw, got;
    da = 1'b0;
    dw = 1'b0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge ref_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    while (!got) begin
      @(negedge ref_clk);
      got = bvalid;
      @(posedge ref_clk);
    end
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge ref_clk);
      t = arready;
      @(posedge ref_clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge ref_clk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
    end
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

/* File: bench/sfs_supervisor_test.sv */
module sfs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sfs_pkg::*;
  logic              ref_clk = 1'b0, srst = 1'b1, uv_det = 1'b0, ov_det = 1'b0, pump_bad_det = 1'b1;
  logic [NUM_CH-1:0] ots_det = '0, power_outputs, high_overcurrent_window;
  logic              warn_threshold_select, irq, win_seen = 1'b0;
  logic [31:0]       rd;
  logic [1:0]        rs;
  int                mismatches = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (|high_overcurrent_window) win_seen <= 1'b1;
  sfs_host host_u (.ref_clk(ref_clk));
  sfs_supervisor #(.RESTART_CYC(50)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .uv_det(uv_det), .ov_det(ov_det), .pump_bad_det(pump_bad_det),
    .ots_det(ots_det), .power_outputs(power_outputs), .high_overcurrent_window(high_overcurrent_window),
    .warn_threshold_select(warn_threshold_select), .irq(irq),
    .s_axi_awaddr(host_u.awaddr), .s_axi_awvalid(host_u.awvalid), .s_axi_awready(host_u.awready),
    .s_axi_wdata(host_u.wdata), .s_axi_wstrb(host_u.wstrb), .s_axi_wvalid(host_u.wvalid),
    .s_axi_wready(host_u.wready), .s_axi_bresp(host_u.bresp), .s_axi_bvalid(host_u.bvalid),
    .s_axi_bready(host_u.bready), .s_axi_araddr(host_u.araddr), .s_axi_arvalid(host_u.arvalid),
    .s_axi_arready(host_u.arready), .s_axi_rdata(host_u.rdata), .s_axi_rresp(host_u.rresp),
    .s_axi_rvalid(host_u.rvalid), .s_axi_rready(host_u.rready));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic co(input logic [4:0] e);
    chk({27'h0000000, power_outputs}, {27'h0000000, e});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, rd, rs);
    chk(rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic t_powerup();
    host_u.wr(ADDR_OUT_CTRL, 32'h0000_001F);
    cyc(20);
    co(5'h00);
    chk({31'h0, warn_threshold_select}, 32'h0);
    pump_bad_det <= 1'b0;
    cyc(10);
    co(5'h1F);
    chk({31'h0, win_seen}, 32'h1);
    uv_det <= 1'b1;
    cyc(100);
    uv_det <= 1'b0;
    cyc(5);
    co(5'h1F);
    $display("powerup and glitch done");
  endtask
  task automatic t_uv_normal();
    uv_det <= 1'b1;
    cyc(160);
    co(5'h00);
    rc(ADDR_SUPV_STAT, 32'h8000_0001);
    rc(ADDR_QUICK_STAT, 32'h8000_0000);
    uv_det <= 1'b0;
    cyc(10);
    co(5'h00);
    rc(ADDR_SUPV_STAT, 32'h8000_0001);
    rc(ADDR_SUPV_STAT, 32'h0000_0000);
    host_u.wr(ADDR_OUT_CTRL, 32'h0000_001F);
    cyc(5);
    co(5'h1F);
    ov_det <= 1'b1;
    cyc(160);
    rc(ADDR_SUPV_STAT, 32'h8000_0002);
    ov_det <= 1'b0;
    cyc(10);
    rc(ADDR_SUPV_STAT, 32'h8000_0002);
    rc(ADDR_SUPV_STAT, 32'h0000_0000);
    $display("undervoltage and overvoltage done");
  endtask
  task automatic t_pump();
    pump_bad_det <= 1'b1;
    cyc(180);
    co(5'h00);
    host_u.wr(ADDR_OUT_CTRL, 32'h0000_001F);
    rc(ADDR_QUICK_STAT, 32'h8000_0001);
    win_seen <= 1'b0;
    pump_bad_det <= 1'b0;
    cyc(10);
    co(5'h1F);
    chk({31'h0, win_seen}, 32'h1);
    rc(ADDR_QUICK_STAT, 32'h8000_0001);
    rc(ADDR_QUICK_STAT, 32'h0000_0000);
    $display("pump failure done");
  endtask
  task automatic t_fail_mode();
    host_u.wr(ADDR_CONFIG, 32'h0000_0001);
    uv_det <= 1'b1;
    cyc(160);
    co(5'h00);
    uv_det <= 1'b0;
    cyc(25);
    co(5'h00);
    cyc(50);
    co(5'h1F);
    $display("fail mode restart done");
  endtask
  task automatic t_regs();
    host_u.wr(ADDR_CONFIG, 32'h0000_0002);
    cyc(3);
    chk({31'h0, warn_threshold_select}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    host_u.wr(ADDR_IRQ_MASK, 32'h0000_000F);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rc(ADDR_IRQ_STAT, 32'h0000_0007);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rc(8'h40, 32'h0000_0000);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    ots_det <= 5'h04;
    cyc(150);
    co(5'h1F);
    cyc(70);
    co(5'h1B);
    rc(ADDR_CH_STAT, 32'h8000_0004);
    ots_det <= 5'h00;
    cyc(5);
    rc(ADDR_CH_STAT, 32'h8000_0004);
    rc(ADDR_CH_STAT, 32'h8000_0000);
    $display("registers, interrupt and overtemperature done");
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_powerup();
    t_uv_normal();
    t_pump();
    t_fail_mode();
    t_regs();
    summarize();
  end
endmodule
